//--- input_sync.sv
// Purpose: Two-flop synchroniser with selectable input sense.
// Assumes: Inputs asynchronous to clk in practice.
// Notes: Polarity applied after second stage only.
module input_sync #(
   parameter int WIDTH = 6
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Data
   input wire logic [WIDTH-1:0] raw,
   input wire logic invert,
   output logic [WIDTH-1:0] active
);
   logic [WIDTH-1:0] s1_r, s1_nxt, s2_r, s2_nxt;
   if (WIDTH < 1) begin : gen_bad_width
      $error("input_sync: WIDTH must be positive");
   end
   always_comb begin
      s1_nxt = raw;
      s2_nxt = s1_r;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         // Both stages hold the idle pin level, so no input looks active
         // for the two cycles in which the pipeline refills after reset.
         s1_r <= {WIDTH{invert}};
         s2_r <= {WIDTH{invert}};
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end
   // Inverted sense is for negative logic settings.
   assign active = s2_r ^ {WIDTH{invert}};
endmodule

//--- pulse_source.sv
// Purpose: Behavioural motion controller that issues step pulses.
// Assumes: Driven from bench tasks; pins follow the drive's input sense.
// Notes: Keeps setup, hold and rate limits on every pulse it sends.
module pulse_source (
   // Clock
   input wire logic clk,
   // Input sense, high means inverted pins
   input wire logic neg,
   // Pins toward the drive
   output logic step_in,
   output logic dir_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic step_a = 1'b0;
   logic dir_a = 1'b0;
   assign step_in = step_a ^ neg;
   assign dir_in = dir_a ^ neg;
   // ==========================================================
   // One pulse
   task automatic pulse(input int w, input logic d);
      @(posedge clk);
      // A reversal waits for standstill, so no steps are lost.
      if (d !== dir_a) begin
         repeat (5000) @(posedge clk);
      end
      dir_a <= d;
      repeat (25) @(posedge clk);
      step_a <= 1'b1;
      repeat (w) @(posedge clk);
      step_a <= 1'b0;
      repeat (100) @(posedge clk);
   endtask
endmodule

//--- step_sequencer.sv
// Purpose: Microstep phase index advanced once per accepted step.
// Assumes: Step strobe is a one-cycle pulse.
// Notes: Index wraps over a full electrical cycle of 4 full steps.
module step_sequencer
   import stepper_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic step,
   input wire logic reverse,
   input wire stepper_pkg::res_t res,
   // Phase position, 20 microsteps per full step
   output logic [6:0] phase_r
);
   logic [6:0] phase_nxt;
   logic [4:0] inc;
   always_comb begin
      case (res)
         RES_FULL: inc = 5'h14;
         RES_HALF: inc = 5'h0a;
         RES_2P5: inc = 5'h08;
         RES_5: inc = 5'h04;
         default: inc = 5'h14;
      endcase
      phase_nxt = phase_r;
      if (step) begin
         if (reverse)
            phase_nxt = (phase_r >= 7'(inc)) ? phase_r - 7'(inc)
                        : 7'(phase_r + 7'd80 - 7'(inc));
         else
            phase_nxt = (phase_r + 7'(inc) >= 7'd80)
                        ? 7'(phase_r + 7'(inc) - 7'd80) : phase_r + 7'(inc);
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) phase_r <= '0;
      else phase_r <= phase_nxt;
   end
endmodule

//--- stepper_ctrl.sv
// Purpose: Input control of a two-phase stepper power stage.
// Assumes: Fault flags arrive as synchronous comparator levels.
// Notes: Chopper regulation and analog shaping lie elsewhere.

module stepper_ctrl #(
   parameter int IDLE_CYCLES = stepper_pkg::IDLE_CYC,
   parameter int READY_CYCLES = stepper_pkg::READY_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Optocoupled inputs, raw
   input wire logic step_in,
   input wire logic dir_in,
   input wire logic boost_in,
   input wire logic deact_in,
   input wire logic rst_in,
   input wire logic brake_in,
   // Selector switches
   input wire logic [3:0] mode_selector_switch,
   input wire logic [3:0] current_selector_switch,
   // Fault flags from analog comparators
   input wire logic overcurrent,
   input wire logic undervoltage,
   input wire logic overtemp,
   // Open-collector outputs, high means transistor conducting
   output logic ready_r,
   output logic error_ok_r,
   output logic brake_release_r,
   // Status LED
   output logic led_green_r,
   output logic led_yellow_r,
   output logic led_red_r,
   // Power stage command
   output logic [7:0] current_da_r,
   output logic motor_enable_r,
   output logic [6:0] phase_r,
   output logic step_done_r
);
   import stepper_pkg::*;

   // Every check below runs on clk and rests while reset is held.
   default clocking chk_clk @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // The idle and ready counters are 22 and 25 bits wide.
   if (IDLE_CYCLES < 1 || IDLE_CYCLES > 4194303 ||
       READY_CYCLES < 1 || READY_CYCLES > 33554431) begin : gen_bad_timing
      $error("stepper_ctrl: timing counts out of range");
   end

   // ==========================================================
   // Switch capture at power-up
   logic [3:0] mode_r, mode_nxt, cursw_r, cursw_nxt;
   logic cap_r, cap_nxt;
   always_comb begin
      cap_nxt = 1'b1;
      mode_nxt = cap_r ? mode_r : mode_selector_switch;
      cursw_nxt = cap_r ? cursw_r : current_selector_switch;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cap_r <= 1'b0;
         mode_r <= '0;
         cursw_r <= '0;
      end else begin
         cap_r <= cap_nxt;
         mode_r <= mode_nxt;
         cursw_r <= cursw_nxt;
      end
   end

   // ==========================================================
   // Input synchronisation and sense
   logic [5:0] act;
   logic s_step, s_dir, s_boost, s_deact, s_rst, s_brake;
   logic sense_neg;
   // Until capture the static switch gives the sense, so the synchroniser
   // comes out of reset at the inactive level and no false edge follows.
   assign sense_neg = cap_r ? mode_r[MODE_NEG_BIT]
                      : mode_selector_switch[MODE_NEG_BIT];
   input_sync #(.WIDTH(6)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .raw({brake_in, rst_in, deact_in, boost_in, dir_in, step_in}),
      .invert(sense_neg),
      .active(act)
   );
   assign {s_brake, s_rst, s_deact, s_boost, s_dir, s_step} = act;

   // ==========================================================
   // Step pulse qualification
   // The step is counted on the trailing edge so a pulse shorter than
   // the minimum width is discarded rather than half-taken.
   logic [7:0] wid_r, wid_nxt;
   logic prev_r, prev_nxt, step_go;
   always_comb begin
      prev_nxt = s_step;
      if (!s_step) wid_nxt = '0;
      else if (wid_r != 8'hff) wid_nxt = wid_r + 8'h01;
      else wid_nxt = wid_r;
      step_go = prev_r && !s_step && (int'(wid_r) >= STEP_MIN_CYC);
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wid_r <= '0;
         prev_r <= 1'b0;
      end else begin
         wid_r <= wid_nxt;
         prev_r <= prev_nxt;
      end
   end

   // ==========================================================
   // Fault latch and ready delay
   logic fault_r, fault_nxt;
   logic [24:0] rdy_cnt_r, rdy_cnt_nxt;
   logic can_run;
   always_comb begin
      fault_nxt = fault_r;
      if (overcurrent || undervoltage || overtemp) fault_nxt = 1'b1;
      else if (s_rst) fault_nxt = 1'b0;
      rdy_cnt_nxt = rdy_cnt_r;
      if (s_rst) rdy_cnt_nxt = '0;
      else if (int'(rdy_cnt_r) < READY_CYCLES)
         rdy_cnt_nxt = rdy_cnt_r + 25'h1;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fault_r <= 1'b0;
         rdy_cnt_r <= '0;
      end else begin
         fault_r <= fault_nxt;
         rdy_cnt_r <= rdy_cnt_nxt;
      end
   end
   assign can_run = (int'(rdy_cnt_r) >= READY_CYCLES) && !s_deact
                    && !fault_r && !s_rst;

   // ==========================================================
   // Current selection
   cur_sel_t cur_r, cur_nxt;
   logic [21:0] idle_r, idle_nxt;
   logic stepping;
   always_comb begin
      cur_nxt = cur_r;
      idle_nxt = idle_r;
      if (!can_run) begin
         cur_nxt = CUR_OFF;
         idle_nxt = '0;
      end else if (step_go) begin
         cur_nxt = CUR_RUN;
         idle_nxt = '0;
      end else if (cur_r == CUR_RUN) begin
         if (int'(idle_r) >= IDLE_CYCLES) cur_nxt = CUR_STOP;
         else idle_nxt = idle_r + 22'h1;
      end else begin
         cur_nxt = CUR_STOP;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cur_r <= CUR_OFF;
         idle_r <= '0;
      end else begin
         cur_r <= cur_nxt;
         idle_r <= idle_nxt;
      end
   end
   assign stepping = (cur_r == CUR_RUN);

   // Run current in 0.1 A units from the selector position.
   function automatic logic [7:0] run_da(input logic [3:0] sel);
      run_da = RUN_TABLE_RESET + 8'({sel, 1'b0}) + 8'(sel >> 1);
   endfunction

   logic [7:0] run_lvl, stop_lvl, base_lvl, cur_da_nxt;
   always_comb begin
      run_lvl = run_da(cursw_r);
      stop_lvl = (run_lvl >> 1) < STOP_MIN_DA ? STOP_MIN_DA
                 : run_lvl >> 1;
      // Follows the next selection, so the current drops in the same
      // cycle as the enable and never lingers after deactivation.
      case (cur_nxt)
         CUR_RUN: base_lvl = run_lvl;
         CUR_STOP: base_lvl = stop_lvl;
         default: base_lvl = 8'h00;
      endcase
      // Boost adds 30 percent, rounded down to 0.1 A.
      if (s_boost)
         cur_da_nxt = 8'((16'(base_lvl) * 16'd13) / 16'd10);
      else
         cur_da_nxt = base_lvl;
   end

   // ==========================================================
   // Phase sequencing
   res_t res;
   logic reverse, step_ok;
   assign res = res_t'(mode_r[MODE_RES_LSB +: 2]);
   assign reverse = s_dir ^ mode_r[MODE_DIR_BIT];
   assign step_ok = step_go && can_run;
   step_sequencer u_seq (
      .clk(clk),
      .reset_n(reset_n),
      .step(step_ok),
      .reverse(reverse),
      .res(res),
      .phase_r(phase_r)
   );

   // ==========================================================
   // Registered outputs
   logic ready_nxt, err_nxt, brk_nxt, g_nxt, y_nxt, r_nxt, en_nxt;
   always_comb begin
      ready_nxt = can_run;
      err_nxt = !fault_r;
      brk_nxt = s_brake && !s_rst && !s_deact && !fault_r;
      en_nxt = can_run;
      r_nxt = fault_r && !s_rst;
      g_nxt = can_run && !stepping;
      y_nxt = can_run && stepping;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ready_r <= 1'b0;
         error_ok_r <= 1'b1;
         brake_release_r <= 1'b0;
         led_green_r <= 1'b0;
         led_yellow_r <= 1'b0;
         led_red_r <= 1'b0;
         current_da_r <= '0;
         motor_enable_r <= 1'b0;
         step_done_r <= 1'b0;
      end else begin
         ready_r <= ready_nxt;
         error_ok_r <= err_nxt;
         brake_release_r <= brk_nxt;
         led_green_r <= g_nxt;
         led_yellow_r <= y_nxt;
         led_red_r <= r_nxt;
         current_da_r <= cur_da_nxt;
         motor_enable_r <= en_nxt;
         step_done_r <= step_ok;
      end
   end

   // ==========================================================
   // Checks
   a_fault_latches: assert property ((fault_r && !s_rst) |=> fault_r)
      else $error("fault dropped");
   a_fault_error_out: assert property ($rose(fault_r) |=> !error_ok_r)
      else $error("error not shown");
   a_short_pulse: assert property (
      (prev_r && !s_step && int'(wid_r) < STEP_MIN_CYC) |=> !step_done_r)
      else $error("short pulse stepped");
   a_deact_off: assert property (
      s_deact |=> (!motor_enable_r && !ready_r && current_da_r == 8'h00))
      else $error("deactivation ignored");
   a_brake_forced: assert property (
      (s_rst || s_deact || fault_r) |=> !brake_release_r)
      else $error("brake not forced off");
   a_step_to_run: assert property (step_ok |=> cur_r == CUR_RUN)
      else $error("no run current");
   a_ready_wait: assert property (s_rst |=> !ready_r ##1 !ready_r)
      else $error("ready too soon");
   a_led_exclusive: assert property (
      !(led_green_r && led_yellow_r) && !(led_red_r && led_green_r))
      else $error("two led colours");
   a_step_phase: assert property (
      step_ok |=> phase_r != $past(phase_r)) else $error("no step");
   a_fault_set: assert property (
      (overcurrent || undervoltage || overtemp) |=> fault_r)
      else $error("fault not latched");
   a_reset_clears: assert property (
      (s_rst && !overcurrent && !undervoltage && !overtemp) |=> !fault_r)
      else $error("fault not cleared");
   a_led_dark_reset: assert property (
      s_rst |=> !(led_green_r || led_yellow_r || led_red_r))
      else $error("led lit in reset");
   a_stop_floor: assert property (
      motor_enable_r |-> current_da_r >= STOP_MIN_DA)
      else $error("current below floor");
   a_idle_return: assert property (
      (can_run && !step_go && cur_r == CUR_RUN
       && int'(idle_r) >= IDLE_CYCLES) |=> cur_r == CUR_STOP)
      else $error("no return to standstill");
endmodule

//--- stepper_pkg.sv
// Purpose: Shared constants for the stepper drive input control.
// Assumes: 20 MHz clock, synchronous active-low reset.
// Notes: Times are kept in their own units and converted here.
package stepper_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_HZ = 20_000_000;
   localparam int STEP_MIN_US = 5;
   localparam int IDLE_MS = 40;
   localparam int READY_DELAY_MS = 500;
   localparam int STEP_MIN_CYC = (STEP_MIN_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int IDLE_CYC = IDLE_MS * (CLK_HZ / 1000);
   localparam int READY_CYC = READY_DELAY_MS * (CLK_HZ / 1000);
   // ==========================================================
   // Mode selector field positions
   localparam int MODE_RES_LSB = 0;
   localparam int MODE_DIR_BIT = 2;
   localparam int MODE_NEG_BIT = 3;
   // ==========================================================
   // Current levels, in units of 0.1 A
   localparam logic [7:0] STOP_MIN_DA = 8'h05;
   localparam logic [7:0] RUN_TABLE_RESET = 8'h0a;
   // Resolution: microsteps per full step, and phase index span.
   localparam logic [4:0] PHASE_SPAN = 5'h14;
   typedef enum logic [1:0] {RES_FULL, RES_HALF, RES_2P5, RES_5} res_t;
   typedef enum {CUR_OFF, CUR_STOP, CUR_RUN} cur_sel_t;
endpackage

//--- testbench.sv
// Purpose: Self-checking bench for the stepper drive input control.
// Assumes: Shortened idle and ready counts given as parameters.
// Notes: Each selector setting needs its own power-up reset.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import stepper_pkg::*;
   localparam int IDLE_N = 400;
   localparam int READY_N = 20;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic boost_a = 1'b0, deact_a = 1'b0, rst_a = 1'b0, brake_a = 1'b0;
   logic [3:0] mode = 4'h0, cur_sel = 4'h0;
   logic [2:0] flt = 3'h0;
   logic ready_r, error_ok_r, brake_release_r, motor_enable_r, step_done_r;
   logic led_green_r, led_yellow_r, led_red_r;
   logic [7:0] current_da_r;
   logic [6:0] phase_r;
   wire step_in, dir_in;
   int n_mismatch = 0, n_compared = 0, n_done = 0, seed, exp_ph;
   always #25 clk = ~clk;
   always @(posedge clk) if (step_done_r === 1'b1) n_done <= n_done + 1;
   pulse_source i_pulse_source (.clk(clk), .neg(mode[3]),
      .step_in(step_in), .dir_in(dir_in));
   stepper_ctrl #(.IDLE_CYCLES(IDLE_N), .READY_CYCLES(READY_N))
   i_stepper_ctrl (.clk(clk), .reset_n(reset_n), .step_in(step_in),
      .dir_in(dir_in), .boost_in(boost_a ^ mode[3]),
      .deact_in(deact_a ^ mode[3]), .rst_in(rst_a ^ mode[3]),
      .brake_in(brake_a ^ mode[3]), .mode_selector_switch(mode),
      .current_selector_switch(cur_sel), .overcurrent(flt[0]),
      .undervoltage(flt[1]), .overtemp(flt[2]), .ready_r(ready_r),
      .error_ok_r(error_ok_r), .brake_release_r(brake_release_r),
      .led_green_r(led_green_r), .led_yellow_r(led_yellow_r),
      .led_red_r(led_red_r), .current_da_r(current_da_r),
      .motor_enable_r(motor_enable_r), .phase_r(phase_r),
      .step_done_r(step_done_r));
   // ==========================================================
   // Expectations
   function automatic logic [7:0] lvl(logic [3:0] s, logic b, logic st);
      int r;
      r = 10 + 2 * s + s / 2;
      if (st) r = (r / 2 < 5) ? 5 : r / 2;
      if (b) r = r * 13 / 10;
      return 8'(r);
   endfunction
   function automatic int span(logic [1:0] res);
      return (res == 2'h0) ? 20 : (res == 2'h1) ? 10 : (res == 2'h2) ? 8 : 4;
   endfunction
   // ==========================================================
   // Checking and closing
   task automatic print_verdict;
      if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic wait_ready;
      int k;
      for (k = 0; k < 200 && ready_r !== 1'b1; k++) @(posedge clk);
      if (ready_r !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: ready never rose", $time);
         print_verdict();
      end
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      logic [3:0] modes [4];
      logic b, d;
      int w, n0;
      modes = '{4'h0, 4'h5, 4'ha, 4'hf};
      seed = 40384;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         reset_n <= 1'b0;
         mode <= modes[i];
         cur_sel <= 4'($random(seed));
         d = 1'($random(seed));
         repeat (16) @(posedge clk);
         reset_n <= 1'b1;
         exp_ph = 0;
         @(posedge clk);
         chk(16'(ready_r), 16'h0000, "ready too early");
         wait_ready();
         for (int k = 0; k < 5; k++) begin
            b = 1'($random(seed));
            w = (k == 0) ? 100 : 100 + ($random(seed) & 63);
            if (k == 4) w = 99;
            boost_a <= b;
            n0 = n_done;
            i_pulse_source.pulse(w, d);
            if (k < 4) begin
               if (d ^ mode[2]) exp_ph = (exp_ph + 80 - span(mode[1:0])) % 80;
               else exp_ph = (exp_ph + span(mode[1:0])) % 80;
            end
            chk(16'(n_done - n0), 16'(k < 4), "step count");
            chk(16'(phase_r), 16'(exp_ph), "phase");
            chk(16'(current_da_r), 16'(lvl(cur_sel, b, 1'b0)),
                "run level");
            chk(16'(led_yellow_r), 16'h0001, "busy led");
         end
         boost_a <= 1'b0;
         repeat (IDLE_N + 20) @(posedge clk);
         chk(16'(current_da_r), 16'(lvl(cur_sel, 1'b0, 1'b1)),
             "stop level");
         chk(16'({led_green_r, ready_r}), 16'h0003, "ready led");
         boost_a <= 1'b1;
         brake_a <= 1'b1;
         repeat (6) @(posedge clk);
         chk(16'(current_da_r), 16'(lvl(cur_sel, 1'b1, 1'b1)),
             "boosted stop");
         chk(16'(brake_release_r), 16'h0001, "brake");
         boost_a <= 1'b0;
         deact_a <= 1'b1;
         repeat (6) @(posedge clk);
         chk(16'({motor_enable_r, current_da_r}), 16'h0000,
             "deact current");
         chk(16'({ready_r, brake_release_r}), 16'h0000,
             "deact ready");
         chk(16'({led_green_r, led_yellow_r, led_red_r}), 16'h0000,
             "deact led");
         deact_a <= 1'b0;
         wait_ready();
         flt <= 3'(1 << (i % 3));
         repeat (6) @(posedge clk);
         chk(16'({error_ok_r, motor_enable_r}), 16'h0000, "fault");
         chk(16'({led_red_r, brake_release_r}), 16'h0002,
             "fault out");
         flt <= 3'h0;
         repeat (6) @(posedge clk);
         chk(16'(error_ok_r), 16'h0000, "fault latch");
         rst_a <= 1'b1;
         repeat (6) @(posedge clk);
         chk(16'(error_ok_r), 16'h0001, "fault clear");
         chk(16'({led_green_r, led_yellow_r, led_red_r,
                  brake_release_r}), 16'h0000, "reset outputs");
         rst_a <= 1'b0;
         repeat (4) @(posedge clk);
         chk(16'(ready_r), 16'h0000, "ready delay");
         wait_ready();
         repeat (4) @(posedge clk);
         chk(16'(brake_release_r), 16'h0001, "brake back");
         brake_a <= 1'b0;
      end
      print_verdict();
   end
endmodule
